// ==== verilog/fsb_security.sv ====
/*
 * Flash sector security and boot configuration: holds the eight guard bytes,
 * the boot page, boot flags and first user configuration byte, screens the program,
 * erase, CRC and boot byte commands against the locks, filters table reads and drives the reset
 * vector and the internal write-enable flag.
 * Assumes a single clock, an AHB-Lite master, an access mode given by the
 * surrounding chip and a flash array and CRC engine that act on op_out.
 */
`timescale 1ns/100ps
module fsb_security
    import fsb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Access mode of the issuing party
    input wire fsb_mode_t access_mode,
    // Table read port
    input wire logic read_req,
    input wire logic [2:0] read_sector,
    input wire logic [7:0] read_raw,
    output fsb_read_t read_out,
    // Flash operation towards array and CRC engine
    output fsb_op_t op_out,
    // Boot and write-enable state
    output logic boot_from_vector,
    output logic [15:0] reset_address,
    output logic write_enable
);
    typedef enum logic {
        ST_IDLE,
        ST_WAIT_KEY
    } fsb_state_t;

    logic wr_strobe;
    logic rd_load;
    logic [7:0] reg_addr;

    logic [NUM_SECTORS-1:0][7:0] guard_reg;
    logic [NUM_SECTORS-1:0][7:0] guard_next;
    logic [7:0] boot_page_reg;
    logic [7:0] boot_page_next;
    logic [7:0] boot_flags_reg;
    logic [7:0] boot_flags_next;
    logic [7:0] first_user_config_byte_reg;
    logic [7:0] first_user_config_byte_next;
    logic [7:0] data_reg;
    logic we_reg;
    logic we_next;
    logic violation_reg;
    logic crc_invalid_reg;
    logic crc_invalid_next;
    logic refused_reg;
    fsb_state_t state_reg;
    fsb_state_t state_next;
    fsb_op_t op_reg;
    fsb_op_t op_next;
    fsb_read_t read_reg;
    logic [31:0] hrdata_reg;
    logic vec_sel_reg;
    logic [15:0] reset_addr_reg;

    fsb_ahb_front u_front (
        .clock(clock),
        .rst(rst),
        .hsel(hsel),
        .htrans(htrans),
        .hwrite(hwrite),
        .haddr(haddr),
        .hready(hready),
        .hreadyout(hreadyout),
        .wr_strobe(wr_strobe),
        .rd_load(rd_load),
        .reg_addr(reg_addr)
    );

    // Command word fields
    wire [7:0] cmd_code = hwdata[7:0];
    wire [3:0] cmd_target = hwdata[11:8];
    wire [2:0] cmd_sector = hwdata[10:8];

    logic sel_code_read;
    logic sel_prog_erase;
    logic sel_insys_erase;
    logic read_locked;
    logic any_code_read;

    fsb_guard_check u_guard (
        .guard(guard_reg),
        .cmd_sector(cmd_sector),
        .read_sector(read_sector),
        .sel_code_read(sel_code_read),
        .sel_prog_erase(sel_prog_erase),
        .sel_insys_erase(sel_insys_erase),
        .read_locked(read_locked),
        .any_code_read(any_code_read)
    );

    // Bus decode
    wire wr_cmd = wr_strobe & (reg_addr == OFS_CMD);
    wire wr_data = wr_strobe & (reg_addr == OFS_DATA);
    wire wr_status = wr_strobe & (reg_addr == OFS_STATUS);
    wire in_guard = (reg_addr >= OFS_GUARD_BASE) & (reg_addr <= OFS_GUARD_LAST);
    wire [2:0] guard_idx = reg_addr[4:2];

    // Mode and lock decode
    wire programmer = (access_mode == MODE_IN_CIRCUIT) | (access_mode == MODE_PARALLEL);
    wire write_arm = boot_flags_reg[FLAG_WRITE_ARM];
    wire cfg_lock = boot_flags_reg[FLAG_CFG_LOCK];
    wire unlock_block = boot_flags_reg[FLAG_UNLOCK_BLOCK];

    wire is_prog = wr_cmd & (cmd_code == CMD_PROGRAM);
    wire is_page = wr_cmd & (cmd_code == CMD_ERASE_PAGE);
    wire is_sect = wr_cmd & (cmd_code == CMD_ERASE_SECTOR);
    wire is_glob = wr_cmd & (cmd_code == CMD_ERASE_GLOBAL);
    wire is_crc_s = wr_cmd & (cmd_code == CMD_CRC_SECTOR);
    wire is_crc_g = wr_cmd & (cmd_code == CMD_CRC_GLOBAL);
    wire is_cfg = wr_cmd & (cmd_code == CMD_PROG_CFG);
    wire is_set_we = wr_cmd & (cmd_code == CMD_SET_WE);
    wire is_clr_we = wr_cmd & (cmd_code == CMD_CLEAR_WE);
    wire is_unlock = wr_cmd & (cmd_code == CMD_CFG_UNLOCK);

    // Read lock alone never enters the program or erase checks
    wire prog_block = sel_prog_erase | sel_insys_erase;
    wire sect_block = sel_insys_erase;
    // A global erase is a programmer-only command
    wire glob_block = ~programmer;
    wire crc_s_block = sel_code_read;
    wire crc_g_block = any_code_read;

    wire changes_array = is_prog | is_page | is_sect | is_glob;
    wire lock_hit = ((is_prog | is_page) & prog_block) | (is_sect & sect_block)
                  | (is_glob & glob_block);
    wire crc_hit = (is_crc_s & crc_s_block) | (is_crc_g & crc_g_block);
    wire set_violation = lock_hit | crc_hit;
    // Array changes also need the write-enable flag; a lock violation wins
    wire we_refused = changes_array & ~lock_hit & ~we_reg;
    wire issue_array = changes_array & ~lock_hit & we_reg;
    wire issue_crc = (is_crc_s & ~crc_s_block) | (is_crc_g & ~crc_g_block);

    wire cfg_guard = is_cfg & (cmd_target < TGT_BOOT_PAGE);
    wire cfg_locked_tgt = is_cfg & ((cmd_target == TGT_BOOT_PAGE)
                        | (cmd_target == TGT_BOOT_FLAGS) | (cmd_target == TGT_FIRST_USER_CONFIG_BYTE));
    wire cfg_refused = cfg_locked_tgt & cfg_lock;
    wire cfg_write = cfg_locked_tgt & ~cfg_lock;
    // Unlock is dropped in in-system modes while the block bit is set
    wire unlock_taken = is_unlock & (programmer | ~unlock_block);
    wire key_ok = (state_reg == ST_WAIT_KEY) & wr_data & (hwdata[7:0] == UNLOCK_KEY);
    wire set_refused = cfg_refused | we_refused;

    // Nonvolatile byte updates
    always_comb begin
        guard_next = guard_reg;
        boot_page_next = boot_page_reg;
        boot_flags_next = boot_flags_reg;
        first_user_config_byte_next = first_user_config_byte_reg;
        if (is_sect & issue_array) begin
            // Read lock and program-erase lock leave only with their sector
            guard_next[cmd_sector] = GUARD_RESET;
        end
        if (is_glob & issue_array) begin
            for (int s = 0; s < NUM_SECTORS; s++) begin
                guard_next[s] = GUARD_RESET;
            end
        end
        if (cfg_guard) begin
            // Programming only sets bits; erase is the sole way back
            guard_next[cmd_sector] = guard_reg[cmd_sector] | (data_reg & GUARD_MASK);
        end
        if (cfg_write & (cmd_target == TGT_BOOT_PAGE)) begin
            boot_page_next = data_reg & BOOT_PAGE_MASK;
        end
        if (cfg_write & (cmd_target == TGT_BOOT_FLAGS)) begin
            boot_flags_next = data_reg & BOOT_FLAGS_MASK;
        end
        if (cfg_write & (cmd_target == TGT_FIRST_USER_CONFIG_BYTE)) begin
            first_user_config_byte_next = data_reg;
        end
        if (key_ok) begin
            boot_flags_next[FLAG_CFG_LOCK] = 1'b0;
            if (programmer) begin
                boot_flags_next[FLAG_UNLOCK_BLOCK] = 1'b0;
            end
        end
    end

    // Unlock sequence: any bus write other than an accepted unlock command ends the wait, the key write included
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (unlock_taken) begin
                    state_next = ST_WAIT_KEY;
                end
            end
            ST_WAIT_KEY: begin
                if (wr_strobe) begin
                    state_next = unlock_taken ? ST_WAIT_KEY : ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Write-enable flag
    always_comb begin
        we_next = we_reg;
        if (!write_arm) begin
            we_next = 1'b1;
        end else if (is_set_we) begin
            we_next = 1'b1;
        end else if (is_clr_we) begin
            we_next = 1'b0;
        end
    end

    always_comb begin
        crc_invalid_next = crc_invalid_reg;
        if (crc_hit) begin
            crc_invalid_next = 1'b1;
        end else if (issue_crc) begin
            crc_invalid_next = 1'b0;
        end else if (wr_status & hwdata[ST_CRC_INVALID]) begin
            crc_invalid_next = 1'b0;
        end
    end

    // Aborted commands never reach the array or the CRC engine
    always_comb begin
        op_next.valid = issue_array | issue_crc;
        op_next.code = cmd_code;
        op_next.sector = cmd_sector;
    end

    // Register read mux
    wire [7:0] guard_rd = guard_reg[guard_idx];
    wire [7:0] status_rd = {3'h0, refused_reg, state_reg == ST_WAIT_KEY, crc_invalid_reg,
                            we_reg, violation_reg};
    wire [31:0] rd_mux = (reg_addr == OFS_DATA) ? {24'h000000, data_reg}
                       : (reg_addr == OFS_STATUS) ? {24'h000000, status_rd}
                       : (reg_addr == OFS_FIRST_USER_CONFIG_BYTE) ? {24'h000000, first_user_config_byte_reg}
                       : (reg_addr == OFS_BOOT_PAGE) ? {24'h000000, boot_page_reg}
                       : (reg_addr == OFS_BOOT_FLAGS) ? {24'h000000, boot_flags_reg}
                       : (reg_addr == OFS_RESET_VEC) ? {16'h0000, reset_addr_reg}
                       : in_guard ? {24'h000000, guard_rd}
                       : 32'h00000000;

    // Boot vector address from the boot page byte
    wire [15:0] vec_addr = {boot_page_reg & BOOT_PAGE_MASK, 8'h00};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            guard_reg <= {NUM_SECTORS{GUARD_RESET}};
            boot_page_reg <= BOOT_PAGE_RESET;
            boot_flags_reg <= BOOT_FLAGS_RESET;
            first_user_config_byte_reg <= FIRST_USER_CONFIG_BYTE_RESET;
        end else begin
            guard_reg <= guard_next;
            boot_page_reg <= boot_page_next;
            boot_flags_reg <= boot_flags_next;
            first_user_config_byte_reg <= first_user_config_byte_next;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_reg <= 8'h00;
            we_reg <= 1'b1;
            state_reg <= ST_IDLE;
            crc_invalid_reg <= 1'b0;
            op_reg <= '0;
        end else begin
            if (wr_data) begin
                data_reg <= hwdata[7:0];
            end
            we_reg <= we_next;
            state_reg <= state_next;
            crc_invalid_reg <= crc_invalid_next;
            op_reg <= op_next;
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            violation_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            violation_reg <= set_violation
                           | (violation_reg & ~(wr_status & hwdata[ST_VIOLATION]));
            refused_reg <= set_refused | (refused_reg & ~(wr_status & hwdata[ST_REFUSED]));
        end
    end

    // Table read filter adds one cycle of latency
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_reg <= '0;
        end else begin
            read_reg.valid <= read_req;
            read_reg.data <= read_locked ? INVALID_READ_DATA : read_raw;
        end
    end

    // Boot outputs track the bytes so a chip reset samples the current value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vec_sel_reg <= 1'b1;
            reset_addr_reg <= 16'h0000;
            hrdata_reg <= 32'h00000000;
        end else begin
            vec_sel_reg <= boot_flags_reg[FLAG_VECTOR_SEL];
            reset_addr_reg <= vec_addr;
            if (rd_load) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign read_out = read_reg;
    assign op_out = op_reg;
    assign boot_from_vector = vec_sel_reg;
    assign reset_address = reset_addr_reg;
    assign write_enable = we_reg;
endmodule : fsb_security

// ==== verilog/fsb_pkg.sv ====
/*
 * Shared constants and carrier types for the flash sector security and boot
 * configuration block: register offsets, command codes, field masks and the
 * values that the nonvolatile bytes hold after reset.
 * Assumes a single 200 MHz clock and a 32-bit AHB-Lite register bus.
 */
package fsb_pkg;
    localparam int NUM_SECTORS = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FIRST_USER_CONFIG_BYTE = 8'h0C;
    localparam logic [7:0] OFS_BOOT_PAGE = 8'h10;
    localparam logic [7:0] OFS_BOOT_FLAGS = 8'h14;
    localparam logic [7:0] OFS_RESET_VEC = 8'h18;
    localparam logic [7:0] OFS_GUARD_BASE = 8'h20;
    localparam logic [7:0] OFS_GUARD_LAST = 8'h3C;

    // Command codes in bits 7:0 of the command word; target in bits 11:8
    localparam logic [7:0] CMD_PROGRAM = 8'h01;
    localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h03;
    localparam logic [7:0] CMD_ERASE_GLOBAL = 8'h04;
    localparam logic [7:0] CMD_CRC_SECTOR = 8'h05;
    localparam logic [7:0] CMD_CRC_GLOBAL = 8'h06;
    localparam logic [7:0] CMD_PROG_CFG = 8'h07;
    localparam logic [7:0] CMD_SET_WE = 8'h08;
    localparam logic [7:0] CMD_CLEAR_WE = 8'h09;
    localparam logic [7:0] CMD_CFG_UNLOCK = 8'h0A;
    localparam logic [7:0] UNLOCK_KEY = 8'h96;

    // Configuration targets of CMD_PROG_CFG above the guard bytes 0..7
    localparam logic [3:0] TGT_BOOT_PAGE = 4'h8;
    localparam logic [3:0] TGT_BOOT_FLAGS = 4'h9;
    localparam logic [3:0] TGT_FIRST_USER_CONFIG_BYTE = 4'hA;

    // Guard byte fields
    localparam int GUARD_CODE_READ = 0;
    localparam int GUARD_PROG_ERASE = 1;
    localparam int GUARD_INSYS_ERASE = 2;
    localparam logic [7:0] GUARD_MASK = 8'h07;
    localparam logic [7:0] GUARD_RESET = 8'h00;

    // Boot page and boot flags fields
    localparam logic [7:0] BOOT_PAGE_MASK = 8'h1F;
    localparam logic [7:0] BOOT_PAGE_RESET = 8'h1F;
    localparam int FLAG_VECTOR_SEL = 0;
    localparam int FLAG_WRITE_ARM = 5;
    localparam int FLAG_CFG_LOCK = 6;
    localparam int FLAG_UNLOCK_BLOCK = 7;
    localparam logic [7:0] BOOT_FLAGS_MASK = 8'hE1;
    localparam logic [7:0] BOOT_FLAGS_RESET = 8'h01;
    localparam logic [7:0] FIRST_USER_CONFIG_BYTE_RESET = 8'h63;

    // Status bits
    localparam int ST_VIOLATION = 0;
    localparam int ST_WRITE_EN = 1;
    localparam int ST_CRC_INVALID = 2;
    localparam int ST_UNLOCK_PEND = 3;
    localparam int ST_REFUSED = 4;

    // Data returned by a table read of a read-locked sector
    localparam logic [7:0] INVALID_READ_DATA = 8'h00;

    typedef enum logic [1:0] {
        MODE_SERIAL_LOADER,
        MODE_IN_APPLICATION,
        MODE_IN_CIRCUIT,
        MODE_PARALLEL
    } fsb_mode_t;

    // Operation handed to the flash array and CRC engine
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [2:0] sector;
    } fsb_op_t;

    // Table read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fsb_read_t;
endpackage : fsb_pkg

// ==== verilog/fsb_ahb_front.sv ====
/*
 * AHB-Lite slave front end: takes the address phase, gives a write strobe
 * during a write data phase and inserts one wait state before read data.
 * Assumes a single slave whose hreadyout is the bus hready.
 */
`timescale 1ns/100ps
module fsb_ahb_front (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Address phase
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] haddr,
    input wire logic hready,
    output logic hreadyout,
    // Towards the register file
    output logic wr_strobe,
    output logic rd_load,
    output logic [7:0] reg_addr
);
    logic wr_phase_reg;
    logic rd_wait_reg;
    logic ready_reg;
    logic [7:0] addr_reg;
    wire take = hsel & htrans[1] & hready;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_phase_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            ready_reg <= 1'b1;
            addr_reg <= 8'h00;
        end else begin
            wr_phase_reg <= take & hwrite;
            rd_wait_reg <= take & ~hwrite;
            // Wait state lets read data come from a flip-flop
            ready_reg <= ~(take & ~hwrite);
            if (take) begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    assign hreadyout = ready_reg;
    assign wr_strobe = wr_phase_reg;
    assign rd_load = rd_wait_reg;
    assign reg_addr = addr_reg;
endmodule : fsb_ahb_front

// ==== verilog/fsb_guard_check.sv ====
/*
 * Per-sector lock decode: splits each guard byte into its three locks and
 * selects the locks of one addressed sector and the read lock of one table-read sector.
 * Assumes guard bytes already carry zero in their reserved bits.
 */
`timescale 1ns/100ps
module fsb_guard_check
    import fsb_pkg::*;
(
    // Guard bytes
    input wire logic [NUM_SECTORS-1:0][7:0] guard,
    // Sector selects
    input wire logic [2:0] cmd_sector,
    input wire logic [2:0] read_sector,
    // Decoded locks
    output logic sel_code_read,
    output logic sel_prog_erase,
    output logic sel_insys_erase,
    output logic read_locked,
    output logic any_code_read
);
    logic [NUM_SECTORS-1:0] code_read;
    logic [NUM_SECTORS-1:0] prog_erase;
    logic [NUM_SECTORS-1:0] insys_erase;

    genvar i;
    generate
        for (i = 0; i < NUM_SECTORS; i++) begin : g_sector
            assign code_read[i] = guard[i][GUARD_CODE_READ];
            assign prog_erase[i] = guard[i][GUARD_PROG_ERASE];
            assign insys_erase[i] = guard[i][GUARD_INSYS_ERASE];
        end
    endgenerate

    assign sel_code_read = code_read[cmd_sector];
    assign sel_prog_erase = prog_erase[cmd_sector];
    assign sel_insys_erase = insys_erase[cmd_sector];
    assign read_locked = code_read[read_sector];
    assign any_code_read = |code_read;
endmodule : fsb_guard_check

// ==== test/fsb_security_asserts.sv ====
/*
 * Checker for fsb_security: bus wait states, table reads, operation issue,
 * boot outputs and write enable.
 * Assumes only the top module ports; bound at the foot of this file.
 */
`timescale 1ns/100ps
module fsb_security_chk
    import fsb_pkg::*;
(
    // Clock, reset and bus
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Mode and table read
    input wire fsb_mode_t access_mode,
    input wire logic read_req,
    input wire logic [2:0] read_sector,
    input wire logic [7:0] read_raw,
    input wire fsb_read_t read_out,
    // Results
    input wire fsb_op_t op_out,
    input wire logic boot_from_vector,
    input wire logic [15:0] reset_address,
    input wire logic write_enable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire taken = hsel && htrans[1] && hready;
    wire wr_cmd = taken && hwrite && haddr[7:0] == OFS_CMD;
    // Recent writes; state outputs may only move shortly after one
    logic [3:0] wr_hist;
    logic [1:0] up_cnt;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_hist <= 4'h0;
            up_cnt <= 2'h0;
        end else begin
            wr_hist <= {wr_hist[2:0], taken && hwrite};
            up_cnt <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
        end
    end
    sequence read_taken; taken && !hwrite; endsequence
    sequence one_wait; !hreadyout ##1 hreadyout; endsequence
    chk_read_wait: assert property (read_taken |=> one_wait)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_hrdata_load: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
    chk_table_valid: assert property (read_req |=> read_out.valid)
        else $error("table read answer missing");
    chk_table_data: assert property (read_req |=> (read_out.data == $past(read_raw) ||
        read_out.data == INVALID_READ_DATA)) else $error("table read data wrong");
    chk_vec_low: assert property (reset_address[7:0] == 8'h00 && reset_address[15:13] == 3'h0)
        else $error("reset address form wrong");
    chk_op_cause: assert property (op_out.valid |-> $past(wr_cmd, 2))
        else $error("operation without command");
    chk_we_fall: assert property ($fell(write_enable) |-> |wr_hist)
        else $error("write enable dropped without command");
    chk_boot_move: assert property (up_cnt == 2'h3 && $changed(boot_from_vector) |-> |wr_hist)
        else $error("boot select moved without write");
    chk_vec_move: assert property (up_cnt == 2'h3 && $changed(reset_address) |-> |wr_hist)
        else $error("reset address moved without write");
endmodule : fsb_security_chk
bind fsb_security fsb_security_chk u_chk (.*);

// ==== test/fsb_flash_model.sv ====
/*
 * Flash array stand-in: answers table reads and counts issued operations.
 * Assumes read_sector is valid while read_req is high.
 */
`timescale 1ns/100ps
module fsb_flash_model
    import fsb_pkg::*;
(
    // Clock
    input wire logic clock,
    // Table read and operations
    input wire logic read_req,
    input wire logic [2:0] read_sector,
    input wire fsb_op_t op,
    output logic [7:0] read_raw,
    output int op_count
);
    logic [7:0] junk = 8'h5A;
    // Idle data lines churn between 8'h5A and 8'hA6, so a stale byte can look like the sector 6 answer
    always @(posedge clock) junk <= ~junk + 8'h01;
    assign read_raw = read_req ? {5'h14, read_sector} : junk;
    initial op_count = 0;
    always @(posedge clock) if (op.valid) op_count <= op_count + 1;
endmodule : fsb_flash_model

// ==== test/flash_sector_security_boot_cfg_test.sv ====
/*
 * Self-checking bench for fsb_security against a reference model.
 * Assumes the flash model answers table reads.
 */
`timescale 1ns/100ps
module flash_sector_security_boot_cfg_test;
    import fsb_pkg::*;
    logic clock = 0, rst = 1, hsel = 0, hwrite = 0, read_req = 0, hreadyout, hresp, bfv, we;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [2:0] rsec = 0;
    logic [7:0] raw;
    logic [15:0] rvec;
    fsb_mode_t mode = MODE_SERIAL_LOADER;
    fsb_read_t rout;
    fsb_op_t op;
    int err_count = 0, checks_done = 0, seed = 42, ops, m_ops = 0;
    int g[8], pg = 'h1F, fl = 1, m_we = 1, st, dat;
    logic [10:0] last_op;
    // Last operation handed out, so code and sector can be compared
    always @(posedge clock) if (op.valid) last_op <= {op.code, op.sector};
    always #2.5 clock = ~clock;
    fsb_security u_fsb_security (.clock(clock), .rst(rst), .hsel(hsel), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .haddr(haddr), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .access_mode(mode),
        .read_req(read_req), .read_sector(rsec), .read_raw(raw), .read_out(rout),
        .op_out(op), .boot_from_vector(bfv), .reset_address(rvec), .write_enable(we));
    fsb_flash_model u_fsb_flash_model (.clock(clock), .read_req(read_req),
        .read_sector(rsec), .op(op), .read_raw(raw), .op_count(ops));
    task automatic end_sim;
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic hwait;
        int n;
        n = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                end_sim();
            end
            @(negedge clock);
        end
        @(posedge clock);
    endtask : hwait
    task automatic bus(input logic w, input int a, input int d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hwait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hwait();
        q = hrdata;
    endtask : bus
    task automatic rd(input int a, input int e);
        bus(1'b0, a, 0);
        chk(q, e);
    endtask : rd
    task automatic setd(input int d);
        bus(1'b1, OFS_DATA, d);
        dat = d & 'hFF;
    endtask : setd
    task automatic mdl(input int c, input int t);
        int s;
        int v;
        int anyc;
        int r;
        s = t & 7;
        v = 0;
        anyc = 0;
        st = 0;
        foreach (g[i]) anyc |= g[i] & 1;
        case (c)
            1, 2: v = (g[s] & 6) != 0;
            3: v = (g[s] & 4) != 0;
            4: v = mode < MODE_IN_CIRCUIT;
            5: v = g[s] & 1;
            6: v = anyc;
            default: ;
        endcase
        r = (c < 5 && !v && !m_we) ? 'h10 : 0;
        if (c < 7 && !v && !r) m_ops++;
        if (c == 3 && !v && !r) g[s] = 0;
        if (c == 4 && !v && !r) foreach (g[i]) g[i] = 0;
        if (c < 7) st = v | r | ((c > 4 && v) ? 4 : 0);
        if (c == 7 && t < 8) g[t] |= dat & 7;
        if (c == 7 && t > 7 && (fl & 'h40)) st = 'h10;
        else if (c == 7 && t == 8) pg = dat & 'h1F;
        else if (c == 7 && t == 9) fl = dat & 'hE1;
        if (c == 8 || c == 9) m_we = (c == 8);
        if (!(fl & 'h20)) m_we = 1;
        st |= m_we << 1;
    endtask : mdl
    task automatic cmd(input int c, input int t);
        bus(1'b1, OFS_CMD, (t << 8) | c);
        mdl(c, t);
        bus(1'b0, OFS_STATUS, 0);
        chk(q & 'h17, st);
        chk(ops, m_ops);
        if (c < 7 && !(st & 'h11)) chk(last_op, (c << 3) | (t & 7));
        bus(1'b1, OFS_STATUS, 'h1F);
    endtask : cmd
    task automatic unlock;
        bus(1'b1, OFS_CMD, 'h0A);
        setd('h96);
        if (!(mode < MODE_IN_CIRCUIT && (fl & 'h80))) fl &= ~'h40;
        if (mode >= MODE_IN_CIRCUIT) fl &= ~'h80;
        rd(OFS_BOOT_FLAGS, fl);
    endtask : unlock
    task automatic tread(input int s, input int e);
        read_req <= 1'b1;
        rsec <= s;
        @(posedge clock);
        read_req <= 1'b0;
        @(negedge clock);
        chk({rout.valid, rout.data}, e);
        @(posedge clock);
    endtask : tread
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_BOOT_PAGE, 'h1F);
        rd(OFS_BOOT_FLAGS, 'h01);
        rd(OFS_FIRST_USER_CONFIG_BYTE, 'h63);
        rd(OFS_RESET_VEC, 'h1F00);
        rd('h44, 0);
        chk(bfv, 1);
        chk(rvec, 'h1F00);
        chk(hresp, 0);
        setd('hFF);
        cmd(7, 1);
        setd('h01);
        cmd(7, 2);
        setd('h02);
        cmd(7, 3);
        tread(1, 'h100);
        tread(2, 'h100);
        tread(3, 'h1A3);
        mode <= MODE_IN_APPLICATION;
        for (int c = 1; c < 7; c++) for (int s = 1; s < 4; s++) cmd(c, s);
        for (int i = 0; i < 8; i++) rd(OFS_GUARD_BASE + 4 * i, g[i]);
        mode <= MODE_PARALLEL;
        cmd(4, 0);
        rd(OFS_GUARD_BASE + 4, 0);
        setd('h21);
        cmd(7, 9);
        cmd(9, 0);
        chk(we, 0);
        cmd(1, 5);
        setd('h01);
        cmd(7, 9);
        chk(we, 1);
        setd($random(seed) & 'h1F);
        cmd(7, 8);
        rd(OFS_RESET_VEC, pg << 8);
        chk(rvec, pg << 8);
        setd('h00);
        cmd(7, 9);
        chk(bfv, 0);
        setd('hC1);
        cmd(7, 9);
        setd('h05);
        cmd(7, 8);
        rd(OFS_BOOT_PAGE, pg);
        cmd(7, 10);
        rd(OFS_FIRST_USER_CONFIG_BYTE, 'h63);
        mode <= MODE_SERIAL_LOADER;
        unlock();
        mode <= MODE_IN_CIRCUIT;
        unlock();
        cmd(7, 8);
        rd(OFS_BOOT_PAGE, pg);
        end_sim();
    end
endmodule : flash_sector_security_boot_cfg_test
